// ---- design/reset_seq_map.svh ----
`ifndef RESET_SEQ_MAP_SVH
`define RESET_SEQ_MAP_SVH
// Register byte addresses on the AXI4-Lite slave.
`define ADDR_RESET_CAUSE 8'h00
`define ADDR_OSC_CTRL 8'h04
`define ADDR_STARTUP_STAT 8'h08
// Reset cause field positions.
`define BIT_TRAP 15
`define BIT_ILLEGAL 14
`define BIT_CFGMIS 9
`define BIT_MEM_POWER 8
`define BIT_PIN_RST 7
`define BIT_SW_RST 6
`define BIT_WDOG_EN 5
`define BIT_WDOG_TMO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWN 1
`define BIT_POR 0
// Power-on value: only brown-out and power-on flags set.
`define RESET_CAUSE_POR_VAL 16'h0003
`define RESET_CAUSE_WMASK 16'hC3FF
// Oscillator control field position and fast RC code.
`define OSC_CUR_LSB 12
`define OSC_FAST_RC_CODE 3'h0
// Timing figures.
`define POWER_UP_TIMER_MS 64
`define POWER_ON_DELAY_US 10
`define CLK_MHZ 100
`define STARTUP_PERIODS 1024
`endif

// ---- design/reset_seq_pkg.sv ----
package reset_seq_pkg;
   // Reset source strobes, one cycle each.
   typedef struct packed {
      logic powerOn;
      logic brownOut;
      logic masterClearPin;
      logic softwareReset;
      logic watchdogTimeout;
      logic configMismatch;
      logic trapConflict;
      logic illegalOperation;
   } reset_src_t;
   // Power-save instruction strobes.
   typedef struct packed {
      logic sleepCmd;
      logic idleCmd;
   } power_save_t;
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_DELAY = 4'h2,
      ST_WAITCLK = 4'h4,
      ST_RUN = 4'h8
   } seq_state_t;
endpackage

// ---- design/reset_cause_and_startup_sequencer.sv ----
`include "reset_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_startup_sequencer #(
   parameter int unsigned POWER_UP_CYCLES = `POWER_UP_TIMER_MS * 1000 * `CLK_MHZ,
   parameter int unsigned POWER_ON_CYCLES = `POWER_ON_DELAY_US * `CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire reset_seq_pkg::reset_src_t resetSrc,
   input wire reset_seq_pkg::power_save_t powerSave,
   input wire logic clockSwitchEnable,
   input wire logic [2:0] oscillatorSelectFuse,
   input wire logic watchdogConfigFuse,
   input wire logic twoSpeedEnable,
   input wire logic crystalSource,
   input wire logic usePll,
   input wire logic pllLocked,
   input wire logic oscTick,
   input wire logic failSafeEnable,
   input wire logic clockValid,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic systemReset,
   output logic coreRun,
   output logic [23:0] programCounterLoad,
   output logic [2:0] systemClockSel,
   output logic watchdogEnable,
   output logic memoryBiasSleep,
   output logic regulatorStandby,
   output logic oscFailTrap,
   output logic flashCtrlReset
);
   localparam logic [2:0] FAST_RC = `OSC_FAST_RC_CODE;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   reset_seq_pkg::seq_state_t state_r;
   logic [15:0] cause_r;
   logic [2:0] curOsc_r;
   logic [31:0] delay_r;
   logic [9:0] startCnt_r;
   logic startDone_r;
   logic [31:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic awHave_r;
   logic wHave_r;
   logic anySrc;
   logic [15:0] wrVal;
   logic wrCause;
   logic clockReady;
   logic primaryReady;
   logic clockFail;

   // Byte-lane merge of a write word into a 16-bit register.
   function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0])
         r[7:0] = d[7:0];
      if (s[1])
         r[15:8] = d[15:8];
      return r;
   endfunction

   // Any source strobe restarts the sequence; software writes never reach here.
   assign anySrc = |resetSrc;
   assign wrCause = awHave_r && wHave_r && !s_axi_bvalid &&
                    (awAddr_r[7:0] == `ADDR_RESET_CAUSE);
   assign wrVal = mergeLanes(cause_r, wData_r, wStrb_r) & `RESET_CAUSE_WMASK;
   // Crystals need the start-up timer; PLL needs lock; two-speed runs on RC at once.
   assign primaryReady = (!crystalSource || startDone_r) && (!usePll || pllLocked);
   assign clockReady = twoSpeedEnable || primaryReady;
   // Monitored clock missing while running: fall back to fast RC at once.
   assign clockFail = state_r == reset_seq_pkg::ST_RUN && failSafeEnable && !clockValid;

   // Reset cause flags: hardware set wins over a software write in the same cycle.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cause_r <= `RESET_CAUSE_POR_VAL;
      else if (resetSrc.powerOn)
         cause_r <= `RESET_CAUSE_POR_VAL;
      else
      begin
         cause_r <= wrCause ? wrVal : cause_r;
         if (powerSave.sleepCmd || powerSave.idleCmd)
            cause_r[`BIT_WDOG_TMO] <= 1'b0;
         if (resetSrc.trapConflict)
            cause_r[`BIT_TRAP] <= 1'b1;
         if (resetSrc.illegalOperation)
            cause_r[`BIT_ILLEGAL] <= 1'b1;
         if (resetSrc.configMismatch)
            cause_r[`BIT_CFGMIS] <= 1'b1;
         if (resetSrc.masterClearPin)
            cause_r[`BIT_PIN_RST] <= 1'b1;
         if (resetSrc.softwareReset)
            cause_r[`BIT_SW_RST] <= 1'b1;
         if (resetSrc.watchdogTimeout)
            cause_r[`BIT_WDOG_TMO] <= 1'b1;
         if (powerSave.sleepCmd)
            cause_r[`BIT_SLEEP] <= 1'b1;
         if (powerSave.idleCmd)
            cause_r[`BIT_IDLE] <= 1'b1;
         if (resetSrc.brownOut)
            cause_r[`BIT_BROWN] <= 1'b1;
      end
   end

   // Current oscillator: fuse on power-on or brown-out, or on any reset while clock switching is disabled; kept on other resets.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         curOsc_r <= FAST_RC;
      else if (!clockSwitchEnable && anySrc)
         curOsc_r <= oscillatorSelectFuse;
      else if (resetSrc.powerOn || resetSrc.brownOut)
         curOsc_r <= oscillatorSelectFuse;
      else if (clockFail)
         curOsc_r <= FAST_RC;
      else if (wrCause == 1'b0 && awHave_r && wHave_r && !s_axi_bvalid &&
               awAddr_r[7:0] == `ADDR_OSC_CTRL && wStrb_r[1])
         curOsc_r <= wData_r[`OSC_CUR_LSB +: 3];
   end

   // Oscillator start-up timer: a 10-bit count of oscillator ticks.
   // It runs during the release delay, so neither wait adds to the other.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         startCnt_r <= 10'h000;
         startDone_r <= 1'b0;
      end
      else if (anySrc)
      begin
         startCnt_r <= 10'h000;
         startDone_r <= 1'b0;
      end
      else if (oscTick && !startDone_r)
      begin
         startCnt_r <= startCnt_r + 10'h001;
         startDone_r <= (startCnt_r == 10'h3FF);
      end
   end

   // Release sequencer: delay chosen by the last reset type.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= reset_seq_pkg::ST_RESET;
         delay_r <= 32'h0000_0000;
      end
      else if (resetSrc.powerOn)
      begin
         state_r <= reset_seq_pkg::ST_DELAY;
         delay_r <= POWER_ON_CYCLES + POWER_UP_CYCLES;
      end
      else if (resetSrc.brownOut)
      begin
         state_r <= reset_seq_pkg::ST_DELAY;
         delay_r <= POWER_UP_CYCLES;
      end
      else if (anySrc)
      begin
         state_r <= reset_seq_pkg::ST_DELAY;
         delay_r <= 32'h0000_0000;
      end
      else
      begin
         case (state_r)
            reset_seq_pkg::ST_RESET:
               state_r <= reset_seq_pkg::ST_DELAY;
            reset_seq_pkg::ST_DELAY:
               if (delay_r == 32'h0000_0000)
                  state_r <= reset_seq_pkg::ST_WAITCLK;
               else
                  delay_r <= delay_r - 32'h0000_0001;
            reset_seq_pkg::ST_WAITCLK:
               if (clockReady || (failSafeEnable && !clockValid))
                  state_r <= reset_seq_pkg::ST_RUN;
            reset_seq_pkg::ST_RUN:
               state_r <= reset_seq_pkg::ST_RUN;
            default:
               state_r <= reset_seq_pkg::ST_RESET;
         endcase
      end
   end

   // System-facing outputs, all registered.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         systemReset <= 1'b1;
         coreRun <= 1'b0;
         programCounterLoad <= 24'h000000;
         systemClockSel <= FAST_RC;
         watchdogEnable <= 1'b1;
         memoryBiasSleep <= 1'b0;
         regulatorStandby <= 1'b1;
         oscFailTrap <= 1'b0;
         flashCtrlReset <= 1'b1;
      end
      else
      begin
         systemReset <= anySrc || state_r == reset_seq_pkg::ST_RESET ||
                        state_r == reset_seq_pkg::ST_DELAY;
         coreRun <= !anySrc && state_r == reset_seq_pkg::ST_RUN;
         programCounterLoad <= 24'h000000;
         // Two-speed start stays on fast RC until the primary source is ready.
         systemClockSel <= (twoSpeedEnable && (state_r != reset_seq_pkg::ST_RUN ||
                           !primaryReady)) || clockFail ? FAST_RC : curOsc_r;
         watchdogEnable <= cause_r[`BIT_WDOG_EN] || watchdogConfigFuse;
         memoryBiasSleep <= cause_r[`BIT_MEM_POWER];
         regulatorStandby <= !cause_r[`BIT_MEM_POWER];
         oscFailTrap <= state_r == reset_seq_pkg::ST_RUN && failSafeEnable &&
                        !clockValid && !anySrc;
         flashCtrlReset <= resetSrc.powerOn;
      end
   end

   // AXI write channel: address and data taken in either order, then response.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= 32'h0000_0000;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (awHave_r && wHave_r && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_r[7:0] == `ADDR_RESET_CAUSE ||
                            awAddr_r[7:0] == `ADDR_OSC_CTRL) && awAddr_r[31:8] == 24'h0 ?
                           RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
         end
      end
   end

   // Ready held high while the channel is empty; keeps one write in flight.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wHave_r && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // AXI read channel: one read at a time, answer one cycle after the address.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= s_axi_araddr[31:8] == 24'h0 &&
                           (s_axi_araddr[7:0] == `ADDR_RESET_CAUSE ||
                            s_axi_araddr[7:0] == `ADDR_OSC_CTRL ||
                            s_axi_araddr[7:0] == `ADDR_STARTUP_STAT) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[7:0])
               `ADDR_RESET_CAUSE:
                  s_axi_rdata <= {16'h0000, cause_r};
               `ADDR_OSC_CTRL:
                  s_axi_rdata <= {17'h00000, curOsc_r, 12'h000};
               `ADDR_STARTUP_STAT:
                  s_axi_rdata <= {24'h000000, state_r, startDone_r, pllLocked,
                                  systemReset, coreRun};
               default:
                  s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Checks.
   AST_TRAP_SET: assert property (@(posedge ref_clk) disable iff (rst)
      resetSrc.trapConflict && !resetSrc.powerOn |=> cause_r[`BIT_TRAP])
      else $error("Trap flag not set.");
   AST_ILLEGAL_SET: assert property (@(posedge ref_clk) disable iff (rst)
      resetSrc.illegalOperation && !resetSrc.powerOn |=> cause_r[`BIT_ILLEGAL])
      else $error("Illegal flag not set.");
   AST_POR_VALUE: assert property (@(posedge ref_clk) disable iff (rst)
      resetSrc.powerOn |=> cause_r == `RESET_CAUSE_POR_VAL)
      else $error("Power-on cause value wrong.");
   AST_WDT_EN: assert property (@(posedge ref_clk) disable iff (rst)
      watchdogConfigFuse |=> watchdogEnable)
      else $error("Watchdog not forced on.");
   AST_SYSTEM_RESET: assert property (@(posedge ref_clk) disable iff (rst)
      anySrc |=> systemReset [*2])
      else $error("System reset not asserted.");
   AST_NO_RUN_IN_RESET: assert property (@(posedge ref_clk) disable iff (rst)
      systemReset |-> !coreRun)
      else $error("Core runs during reset.");
   AST_WATCHDOG_TIMEOUT_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (rst)
      powerSave.sleepCmd && !resetSrc.watchdogTimeout |=> !cause_r[`BIT_WDOG_TMO])
      else $error("Watchdog flag not cleared.");
   AST_FAIL_TRAP: assert property (@(posedge ref_clk) disable iff (rst)
      oscFailTrap |-> systemClockSel == FAST_RC)
      else $error("Trap without fast RC.");
   AST_SWR_NO_RESET: assert property (@(posedge ref_clk) disable iff (rst)
      wrCause && !anySrc && state_r == reset_seq_pkg::ST_RUN |=> !systemReset)
      else $error("Flag write reset the device.");
   COV_POR: cover property (@(posedge ref_clk) disable iff (rst) resetSrc.powerOn);
   COV_RUN: cover property (@(posedge ref_clk) disable iff (rst) $rose(coreRun));
   COV_WRITE: cover property (@(posedge ref_clk) disable iff (rst) wrCause);
   COV_TRAP: cover property (@(posedge ref_clk) disable iff (rst) oscFailTrap);
endmodule
`default_nettype wire

// ---- tb/osc_partner_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module osc_partner_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pllHold,
   input wire logic clockDrop,
   output logic oscTick,
   output logic pllLocked,
   output logic clockValid
);
   // The oscillator ticks every second cycle and stands still once it has failed.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         oscTick <= 1'b0;
      end
      else
      begin
         oscTick <= !oscTick && !clockDrop;
      end
   end
   // A dead oscillator can never look locked, so lock also follows the failure.
   assign pllLocked = !pllHold && !clockDrop;
   assign clockValid = !clockDrop;
endmodule
`default_nettype wire

// ---- tb/reset_cause_and_startup_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_map.svh"
module reset_cause_and_startup_sequencer_test;
   localparam int PU = 20;
   localparam int PO = 5;
   logic ref_clk, rst, clockSwitchEnable, watchdogConfigFuse, twoSpeedEnable, crystalSource;
   logic usePll, pllLocked, oscTick, failSafeEnable, clockValid, pllHold, clockDrop;
   logic [2:0] oscillatorSelectFuse, systemClockSel;
   reset_seq_pkg::reset_src_t resetSrc;
   reset_seq_pkg::power_save_t powerSave;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic systemReset, coreRun, watchdogEnable, memoryBiasSleep, regulatorStandby;
   logic oscFailTrap, flashCtrlReset;
   logic [23:0] programCounterLoad;
   int error_cnt, n_checks, cnt;
   logic [7:0] srcVec [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
   int bitPos [6] = '{7, 6, 4, 9, 15, 14};

   reset_cause_and_startup_sequencer #(.POWER_UP_CYCLES(PU), .POWER_ON_CYCLES(PO)) DUT (.*);
   osc_partner_model partner (.*);

   // Free-running 100 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Address and data are offered together and each is dropped once taken.
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (n < 50)
      begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            n = 100;
         end
      end
      if (n == 50) check(1'b0, 1'b1);
   endtask

   task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 50)
      begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            n = 100;
         end
      end
      if (n == 50) check(1'b0, 1'b1);
   endtask

   task automatic regChk(input logic [31:0] a, input logic [15:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      check(d[15:0], exp);
   endtask

   // One-cycle strobe on the reset sources and power-save commands together.
   task automatic pulse(input logic [9:0] v);
      @(posedge ref_clk);
      {resetSrc, powerSave} <= v;
      @(posedge ref_clk);
      {resetSrc, powerSave} <= '0;
      @(negedge ref_clk);
   endtask

   task automatic relCount(output int c);
      c = 0;
      while (systemReset !== 1'b0 && c < 5000)
      begin
         @(negedge ref_clk);
         c++;
      end
   endtask

   task automatic waitRun(input int lim);
      int n;
      n = 0;
      while (coreRun !== 1'b1 && n < lim)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   // Bounded by the crystal start-up, the longest wait in the run.
   initial
   begin
      #200000;
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      final_report;
   end

   initial
   begin
      error_cnt = 0;
      n_checks = 0;
      rst = 1'b1;
      {resetSrc, powerSave} = '0;
      {clockSwitchEnable, watchdogConfigFuse, twoSpeedEnable, crystalSource} = 4'h8;
      {usePll, failSafeEnable, pllHold, clockDrop} = 4'h0;
      oscillatorSelectFuse = 3'h2;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      waitRun(100);
      check(coreRun, 1'b1);
      check(programCounterLoad, 24'h000000);
      regChk(`ADDR_RESET_CAUSE, 16'h0003);
      axiRead(32'h0000000C, rd, rsp);
      check(rsp, 2'h2);
      check(rd, 32'h0);
      axiWrite(`ADDR_RESET_CAUSE, 32'h0000FFFF);
      regChk(`ADDR_RESET_CAUSE, 16'hC3FF);
      check(systemReset, 1'b0);
      check({memoryBiasSleep, regulatorStandby, watchdogEnable}, 3'h5);
      axiWrite(`ADDR_RESET_CAUSE, 32'h0);
      repeat (2) @(posedge ref_clk);
      check({memoryBiasSleep, regulatorStandby, watchdogEnable}, 3'h2);
      watchdogConfigFuse <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(watchdogEnable, 1'b1);
      watchdogConfigFuse <= 1'b0;
      // Each warm reset leaves its own flag only and releases without delay.
      for (int i = 0; i < 6; i++)
      begin
         axiWrite(`ADDR_RESET_CAUSE, 32'h0);
         pulse({srcVec[i], 2'h0});
         check(systemReset, 1'b1);
         relCount(cnt);
         check(cnt <= 3, 1'b1);
         waitRun(100);
         regChk(`ADDR_RESET_CAUSE, 16'h0001 << bitPos[i]);
      end
      axiWrite(`ADDR_RESET_CAUSE, 32'h0);
      pulse(10'h020);
      relCount(cnt);
      waitRun(100);
      pulse(10'h002);
      regChk(`ADDR_RESET_CAUSE, 16'h0008);
      pulse(10'h001);
      regChk(`ADDR_RESET_CAUSE, 16'h000C);
      // Power-on wipes stale flags and takes the longest release delay.
      axiWrite(`ADDR_RESET_CAUSE, 32'h0000C0F0);
      pulse(10'h200);
      check(flashCtrlReset, 1'b1);
      relCount(cnt);
      check(cnt >= PO + PU && cnt <= PO + PU + 4, 1'b1);
      waitRun(100);
      regChk(`ADDR_RESET_CAUSE, 16'h0003);
      check(systemClockSel, 3'h2);
      axiWrite(`ADDR_RESET_CAUSE, 32'h0);
      pulse(10'h100);
      relCount(cnt);
      check(cnt >= PU && cnt <= PU + 4, 1'b1);
      waitRun(100);
      regChk(`ADDR_RESET_CAUSE, 16'h0002);
      oscillatorSelectFuse <= 3'h6;
      pulse(10'h080);
      relCount(cnt);
      waitRun(100);
      check(systemClockSel, 3'h2);
      axiRead(`ADDR_OSC_CTRL, rd, rsp);
      check(rd[14:12], 3'h2);
      clockSwitchEnable <= 1'b0;
      pulse(10'h080);
      relCount(cnt);
      waitRun(100);
      check(systemClockSel, 3'h6);
      // Crystal start-up: count oscillator periods until the core may run.
      crystalSource <= 1'b1;
      pulse(10'h200);
      cnt = 0;
      while (coreRun !== 1'b1 && cnt < 1100)
      begin
         @(posedge ref_clk);
         if (oscTick) cnt++;
      end
      check(cnt >= 1023 && cnt <= 1026, 1'b1);
      @(posedge ref_clk);
      twoSpeedEnable <= 1'b1;
      pulse(10'h200);
      relCount(cnt);
      waitRun(40);
      check(coreRun, 1'b1);
      check(systemClockSel, `OSC_FAST_RC_CODE);
      @(posedge ref_clk);
      {twoSpeedEnable, crystalSource, usePll, pllHold} <= 4'h3;
      pulse(10'h100);
      relCount(cnt);
      repeat (10) @(negedge ref_clk);
      check({systemReset, coreRun}, 2'h0);
      @(posedge ref_clk);
      pllHold <= 1'b0;
      waitRun(20);
      check(coreRun, 1'b1);
      @(posedge ref_clk);
      {usePll, failSafeEnable, clockDrop} <= 3'h3;
      pulse(10'h080);
      relCount(cnt);
      waitRun(40);
      check({coreRun, oscFailTrap}, 2'h3);
      check(systemClockSel, `OSC_FAST_RC_CODE);
      final_report;
   end
endmodule
`default_nettype wire
